/* hpdb_host_model.sv */
// behavioural host processor on the byte-wide host bus
`timescale 1ns/10ps
module hpdb_host_model (
  input  wire logic            pclk,
  output hpdb_pkg::hpdb_host_bus_t bus,
  input  wire logic [7:0]      host_data_out,
  input  wire logic            host_data_oe
);
  initial bus = hpdb_pkg::HOST_BUS_IDLE;
  // one host transfer, always started by the host; data line inverted once released
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge pclk);
    bus.addr <= a;
    bus.data <= d;
    repeat (3) @(posedge pclk);
    bus.cs_n <= 1'b0;
    bus.wr_n <= !wr;
    bus.rd_n <= wr;
    repeat (5) @(posedge pclk);
    q = (host_data_oe === 1'b1) ? host_data_out : 8'hxx;
    bus.cs_n <= 1'b1;
    bus.wr_n <= 1'b1;
    bus.rd_n <= 1'b1;
    repeat (3) @(posedge pclk);
    bus.data <= ~d;
    repeat (6) @(posedge pclk);
  endtask : xfer
  // send a word: wait for empty transmit bytes, low byte written last
  task automatic send_word(input logic [23:0] w);
    logic [7:0] s;
    xfer(1'b0, hpdb_pkg::HOST_STATUS_ADR, 8'h00, s);
    while (s[hpdb_pkg::TX_EMPTY_BIT] !== 1'b1) begin
      xfer(1'b0, hpdb_pkg::HOST_STATUS_ADR, 8'h00, s);
    end
    xfer(1'b1, hpdb_pkg::HOST_BYTE_HI_ADR, w[23:16], s);
    xfer(1'b1, hpdb_pkg::HOST_BYTE_MD_ADR, w[15:8], s);
    xfer(1'b1, hpdb_pkg::HOST_BYTE_LO_ADR, w[7:0], s);
  endtask : send_word
endmodule : hpdb_host_model

/* hpdb_host_port.sv */
// host port double-buffered data path with APB core side and async byte-wide host side
`timescale 1ns/10ps
//
// Functional notes
// - port is a slave only; the host starts every host bus transfer
// - separate double-buffered receive and transmit paths, host stage plus core stage
// - host writes load tx bytes, reads return rx bytes, same addresses
// - host-to-core path ends in core receive word; reverse starts at transmit word
// - core reaches data only through its 24-bit receive and transmit words
// - words move between stages automatically when source full and destination free
// - host tx bytes move to core receive word only while it is empty
// - core transmit word moves to host rx bytes only once they are empty
// - core software checks tx-empty before writing the transmit word
// - core status bit 1 is set while the transmit word can accept data
// - core status bit 0 is set while the receive word holds unread data
// - host status bit 1 is set while host tx bytes are empty
// - host status bit 0 is set while host rx bytes hold unread data
// - core control bits 4:3 appear read-only in host status bits 4:3
// - host control bits 4:3 appear read-only in core status bits 4:3
// - host writes the byte at address 7 last; that write starts the move
// - core read of receive word clears full; core write of transmit clears empty
//
// Timing notes
// apb: the first access edge takes a request; pready pulses one cycle later
// apb: prdata and pslverr stand only with pready; prdata is zero otherwise
// apb: unknown offsets and wrong directions answer with pslverr and change nothing
// apb: 0x000 control rw, 0x004 status ro, 0x008 receive word ro, 0x00c transmit word wo
// apb: writes ignore bits 31:24; reads return zero above the word
// apb: back-to-back transfers are fine; a new setup may follow the answer at once
// host: every pin passes two flip-flops; a strobe under three clocks may be missed
// host: address and data stand through the strobe and three clocks before release
// host: a write is taken at strobe release with the last low sample of address and data
// host: read data and its output enable follow three clocks after the strobe falls
// host: the output enable drops three clocks after the read strobe is released
// host: leave at least three idle clocks between two strobes
// host: strobes must idle high for three clocks after reset is released
// host: 0 control, 2 status, 5 high byte, 6 middle byte, 7 low byte
// host: writes to other addresses are ignored; reads of 1, 3 and 4 return zero
// lanes: byte 5 carries bits 23:16, byte 6 bits 15:8, byte 7 bits 7:0
// lanes: a host read of byte 7 frees the receive bytes for the next word
// status: core bit 0 receive full, bit 1 transmit empty, bits 4:3 host flags
// status: host bit 0 receive full, bit 1 transmit empty, bits 4:3 core flags
// moves: a word moves one edge after its source is full and its destination empty
// moves: a host write of byte 7 wins over a move out of the transmit bytes
// reset: both empty flags set, both full flags clear, all four flags zero
// reset: all outputs low; host_data_out then follows the synchronised host address, the others wait for an access or read strobe
// hazard: a host write while the transmit bytes are full overwrites them
// hazard: a core write while the transmit word is full overwrites it
// hazard: the host cannot read back what it wrote; reads return received bytes
// limitation: only the big-endian byte order of the three-byte word is served
// limitation: no interrupt, dma or host request logic; both sides poll the flags
// ce: low freezes every flip-flop, the synchronisers and the apb answer included
module hpdb_host_port #(
  parameter int WORD_W = 24
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave, core side
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // asynchronous host byte bus, dual strobe, active low
  input  wire logic        host_cs_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [2:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe
);

  // the byte lanes below are laid out for a three-byte word only
  if (WORD_W != 24) begin : g_bad_width
    $error("hpdb_host_port: WORD_W must be 24");
  end

  // host pin synchroniser and edge history
  hpdb_pkg::hpdb_host_bus_t host_raw;
  hpdb_pkg::hpdb_host_bus_t host_meta;
  hpdb_pkg::hpdb_host_bus_t host_sync;
  hpdb_pkg::hpdb_host_bus_t host_prev;

  // host side stages
  wire  [WORD_W-1:0] host_tx_word;       // host_tx_byte_high:mid:low
  logic              host_tx_full;
  wire  [WORD_W-1:0] host_rx_word;       // host_rx_byte_high:mid:low
  logic              host_rx_full_flag;

  // core side stages
  logic [WORD_W-1:0] core_receive_word;
  logic              core_rx_full_flag;
  logic [WORD_W-1:0] core_transmit_word;
  logic              core_tx_full;

  // general-purpose flags, two each way
  logic [1:0]        core_to_host_flags;
  logic [1:0]        host_to_core_flags;

  // the host pins gathered into one sample
  assign host_raw = '{cs_n: host_cs_n, rd_n: host_rd_n, wr_n: host_wr_n,
                      addr: host_addr, data: host_data_in};

  // two flip-flops before any logic looks at the host pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_meta <= hpdb_pkg::HOST_BUS_IDLE;
      host_sync <= hpdb_pkg::HOST_BUS_IDLE;
      host_prev <= hpdb_pkg::HOST_BUS_IDLE;
    end else if (ce) begin
      host_meta <= host_raw;
      host_sync <= host_meta;
      host_prev <= host_sync;
    end
  end

  // host strobe events, taken at strobe release with the stable previous sample
  wire host_wr_done = !host_prev.wr_n && host_sync.wr_n && !host_prev.cs_n;
  wire host_rd_done = !host_prev.rd_n && host_sync.rd_n && !host_prev.cs_n;
  wire host_rd_act  = !host_sync.rd_n && !host_sync.cs_n;

  // write and read targets, decoded from the last low sample of the address
  wire host_wr_lo   = host_wr_done && (host_prev.addr == hpdb_pkg::HOST_BYTE_LO_ADR);
  wire host_wr_ctrl = host_wr_done && (host_prev.addr == hpdb_pkg::HOST_CTRL_ADR);
  wire host_rd_lo   = host_rd_done && (host_prev.addr == hpdb_pkg::HOST_BYTE_LO_ADR);

  // host transmit byte lanes; lane 0 is the low byte, at the highest host address
  localparam int LANES = WORD_W / 8;
  for (genvar lane = 0; lane < LANES; lane++) begin : g_tx_lane
    logic [7:0] lane_byte;
    wire        lane_wr = host_wr_done &&
                          (host_prev.addr == 3'(hpdb_pkg::HOST_BYTE_LO_ADR - 3'(lane)));
    // each lane keeps its byte until the host writes that lane again
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lane_byte <= hpdb_pkg::WORD_RST[8*lane +: 8];
      end else if (ce && lane_wr) begin
        lane_byte <= host_prev.data;
      end
    end
    assign host_tx_word[8*lane +: 8] = lane_byte;
  end

  // host side status byte
  wire host_tx_empty_flag = !host_tx_full;
  wire [7:0] host_side_status = {3'h0, core_to_host_flags, 1'b0,
                                 host_tx_empty_flag,
                                 host_rx_full_flag};
  wire [7:0] host_side_control = {3'h0, host_to_core_flags, 3'h0};

  // host read mux; tx bytes are never readable, only rx bytes
  wire [7:0] next_host_data_out =
    (host_sync.addr == hpdb_pkg::HOST_BYTE_HI_ADR) ? host_rx_word[23:16] :
    (host_sync.addr == hpdb_pkg::HOST_BYTE_MD_ADR) ? host_rx_word[15:8]  :
    (host_sync.addr == hpdb_pkg::HOST_BYTE_LO_ADR) ? host_rx_word[7:0]   :
    (host_sync.addr == hpdb_pkg::HOST_STATUS_ADR)  ? host_side_status    :
    (host_sync.addr == hpdb_pkg::HOST_CTRL_ADR)    ? host_side_control   : 8'h00;

  // automatic moves between the stages
  wire move_to_core = host_tx_full && !core_rx_full_flag;
  wire move_to_host = core_tx_full && !host_rx_full_flag;

  // apb decode; one wait state so every answer comes from a flip-flop
  wire apb_access  = psel && penable && !pready;
  wire apb_wr      = apb_access && pwrite;
  wire apb_rd      = apb_access && !pwrite;

  // offset decode
  wire sel_ctrl    = (paddr == hpdb_pkg::CORE_CTRL_OFS);
  wire sel_status  = (paddr == hpdb_pkg::CORE_STATUS_OFS);
  wire sel_rx_word = (paddr == hpdb_pkg::CORE_RX_WORD_OFS);
  wire sel_tx_word = (paddr == hpdb_pkg::CORE_TX_WORD_OFS);

  // side effects of a taken access
  wire core_rd_rx  = apb_rd && sel_rx_word;
  wire core_wr_tx  = apb_wr && sel_tx_word;
  wire core_wr_ctl = apb_wr && sel_ctrl;

  // refusals: unknown offset or wrong direction
  wire addr_bad    = !(sel_ctrl || sel_status || sel_rx_word || sel_tx_word);
  wire dir_bad     = (pwrite && (sel_status || sel_rx_word)) || (!pwrite && sel_tx_word);

  // core status word
  wire core_tx_empty_flag = !core_tx_full;
  wire [31:0] core_port_status = {27'h0, host_to_core_flags, 1'b0,
                                  core_tx_empty_flag,
                                  core_rx_full_flag};
  wire [31:0] core_port_control = {27'h0, core_to_host_flags, 3'h0};

  wire [31:0] next_prdata =
    !apb_rd     ? 32'h00000000 :
    sel_ctrl    ? core_port_control :
    sel_status  ? core_port_status :
    sel_rx_word ? {8'h00, core_receive_word} : 32'h00000000;

  // host transmit full flag and host control flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_full       <= hpdb_pkg::FULL_RST;
      host_to_core_flags <= hpdb_pkg::FLAGS_RST;
    end else if (ce) begin
      if (host_wr_ctrl) begin
        host_to_core_flags <= host_prev.data[hpdb_pkg::FLAG_HI_BIT:hpdb_pkg::FLAG_LO_BIT];
      end
      // writing the low byte marks the word ready; the set wins over the move
      if (host_wr_lo) begin
        host_tx_full <= 1'b1;
      end else if (move_to_core) begin
        host_tx_full <= 1'b0;
      end
    end
  end

  // core receive word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_receive_word <= hpdb_pkg::WORD_RST;
      core_rx_full_flag <= hpdb_pkg::FULL_RST;
    end else if (ce) begin
      if (move_to_core) begin
        core_receive_word <= host_tx_word;
        core_rx_full_flag <= 1'b1;
      end else if (core_rd_rx) begin
        core_rx_full_flag <= 1'b0;
      end
    end
  end

  // core transmit word and core control flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_transmit_word <= hpdb_pkg::WORD_RST;
      core_tx_full       <= hpdb_pkg::FULL_RST;
      core_to_host_flags <= hpdb_pkg::FLAGS_RST;
    end else if (ce) begin
      if (core_wr_ctl) begin
        core_to_host_flags <= pwdata[hpdb_pkg::FLAG_HI_BIT:hpdb_pkg::FLAG_LO_BIT];
      end
      // a write while full overwrites the word; software polls first
      if (core_wr_tx) begin
        core_transmit_word <= pwdata[WORD_W-1:0];
        core_tx_full       <= 1'b1;
      end else if (move_to_host) begin
        core_tx_full <= 1'b0;
      end
    end
  end

  // host receive byte lanes, all loaded together when a word moves over
  for (genvar lane = 0; lane < LANES; lane++) begin : g_rx_lane
    logic [7:0] lane_byte;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lane_byte <= hpdb_pkg::WORD_RST[8*lane +: 8];
      end else if (ce && move_to_host) begin
        lane_byte <= core_transmit_word[8*lane +: 8];
      end
    end
    assign host_rx_word[8*lane +: 8] = lane_byte;
  end

  // host receive full flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rx_full_flag <= hpdb_pkg::FULL_RST;
    end else if (ce) begin
      if (move_to_host) begin
        host_rx_full_flag <= 1'b1;
      end else if (host_rd_lo) begin
        host_rx_full_flag <= 1'b0;
      end
    end
  end

  // host data bus drivers, only during a synchronised read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else if (ce) begin
      host_data_out <= next_host_data_out;
      host_data_oe  <= host_rd_act;
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata  <= next_prdata;
      pready  <= apb_access;
      pslverr <= apb_access && (addr_bad || dir_bad);
    end
  end

endmodule : hpdb_host_port

/* hpdb_host_port_props.sv */
// port timing checker of the host port data path
`timescale 1ns/10ps
module hpdb_host_port_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        host_cs_n,
  input wire logic        host_rd_n,
  input wire logic        host_data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer timing and content
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_take_answer: assert property (psel && penable && !pready && ce |=> pready)
    else $error("access not answered next cycle");
  a_idle_rdata: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_word_width: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
    else $error("read data above the word width");
  a_bad_addr: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr)
    else $error("unmapped address not refused");
  a_wrong_dir: assert property (pready && (pwrite ? (paddr == hpdb_pkg::CORE_STATUS_OFS ||
    paddr == hpdb_pkg::CORE_RX_WORD_OFS) : paddr == hpdb_pkg::CORE_TX_WORD_OFS) |-> pslverr)
    else $error("wrong direction not refused");
  a_ctrl_ok: assert property (pready && paddr == hpdb_pkg::CORE_CTRL_OFS |-> !pslverr)
    else $error("control access refused");
  // host data drive only during a host read
  a_oe_on_read: assert property ($rose(host_data_oe) |-> !host_rd_n && !host_cs_n)
    else $error("host data driven without a read strobe");
  a_oe_release: assert property ($rose(host_rd_n) |-> ##[1:5] !host_data_oe)
    else $error("host data still driven after read");
endmodule : hpdb_host_port_props

bind hpdb_host_port hpdb_host_port_props hpdb_host_port_props_inst (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .host_cs_n, .host_rd_n, .host_data_oe);

/* hpdb_pkg.sv */
// package of constants and carriers for the host port double-buffered path
package hpdb_pkg;
  // core side register byte offsets on the APB bus
  localparam logic [11:0] CORE_CTRL_OFS    = 12'h000;
  localparam logic [11:0] CORE_STATUS_OFS  = 12'h004;
  localparam logic [11:0] CORE_RX_WORD_OFS = 12'h008;
  localparam logic [11:0] CORE_TX_WORD_OFS = 12'h00c;

  // host side byte addresses on the host bus
  localparam logic [2:0] HOST_CTRL_ADR    = 3'h0;
  localparam logic [2:0] HOST_STATUS_ADR  = 3'h2;
  localparam logic [2:0] HOST_BYTE_HI_ADR = 3'h5;
  localparam logic [2:0] HOST_BYTE_MD_ADR = 3'h6;
  localparam logic [2:0] HOST_BYTE_LO_ADR = 3'h7;

  // status and control field positions
  localparam int RX_FULL_BIT  = 0;
  localparam int TX_EMPTY_BIT = 1;
  localparam int FLAG_LO_BIT  = 3;
  localparam int FLAG_HI_BIT  = 4;

  // values after reset
  localparam logic [1:0]  FLAGS_RST = 2'h0;
  localparam logic [23:0] WORD_RST  = 24'h000000;
  localparam logic        FULL_RST  = 1'b0;

  // one sample of the asynchronous host bus pins
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } hpdb_host_bus_t;

  localparam hpdb_host_bus_t HOST_BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                               addr: 3'h0, data: 8'h00};
endpackage : hpdb_pkg

/* tb_hpdb_host_port.sv */
// self-checking bench of the host port data path
`timescale 1ns/10ps
module tb_hpdb_host_port;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e, host_data_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0]  host_data_out, q8;
  logic [47:0] w = 48'h123456789abc;
  logic [12:0] bad [4] = '{13'h1004, 13'h1008, 13'h000c, 13'h0010};
  int          miscompares = 0, check_count = 0;
  hpdb_pkg::hpdb_host_bus_t bus;
  always #12.5 pclk = ~pclk;
  hpdb_host_port hpdb_host_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_cs_n(bus.cs_n),
    .host_rd_n(bus.rd_n), .host_wr_n(bus.wr_n), .host_addr(bus.addr),
    .host_data_in(bus.data), .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  hpdb_host_model hpdb_host_model_inst (.pclk(pclk), .bus(bus),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  // compare and count
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    check(n, r, x);
    check("read error", {31'h0, e}, 32'h0);
  endtask : rd
  task automatic hrd(input logic [2:0] a, input logic [31:0] x, input string n);
    hpdb_host_model_inst.xfer(1'b0, a, 8'h00, q8);
    check(n, {24'h0, q8}, x);
  endtask : hrd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    #(25 * 8000);
    miscompares++;
    stop_test();
  end
  // test sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h2, "core status");
    hrd(hpdb_pkg::HOST_STATUS_ADR, 32'h02, "host status");
    $display("test reset done");
    apb(1'b1, hpdb_pkg::CORE_CTRL_OFS, 32'h18);
    hpdb_host_model_inst.xfer(1'b1, hpdb_pkg::HOST_CTRL_ADR, 8'h18, q8);
    hrd(hpdb_pkg::HOST_STATUS_ADR, 32'h1a, "host flags");
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h1a, "core flags");
    $display("test flags done");
    hpdb_host_model_inst.send_word(24'ha1b2c3);
    hpdb_host_model_inst.send_word(24'hd4e5f6);
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h1b, "core rx full");
    hrd(hpdb_pkg::HOST_STATUS_ADR, 32'h18, "host tx held");
    rd(hpdb_pkg::CORE_RX_WORD_OFS, 32'ha1b2c3, "rx word one");
    rd(hpdb_pkg::CORE_RX_WORD_OFS, 32'hd4e5f6, "rx word two");
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h1a, "core rx drained");
    $display("test host to core done");
    apb(1'b1, hpdb_pkg::CORE_TX_WORD_OFS, 32'h123456);
    apb(1'b1, hpdb_pkg::CORE_TX_WORD_OFS, 32'h789abc);
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h18, "core tx held");
    hrd(hpdb_pkg::HOST_STATUS_ADR, 32'h1b, "host rx full");
    for (int i = 0; i < 6; i++) hrd(3'h5 + 3'(i % 3), 32'(w[47 - 8 * i -: 8]), "rx byte");
    hrd(hpdb_pkg::HOST_STATUS_ADR, 32'h1a, "host rx drained");
    $display("test core to host done");
    for (int i = 0; i < 4; i++) begin
      apb(bad[i][12], bad[i][11:0], 32'hffffff);
      check("refused error", {31'h0, e}, 32'h1);
      check("refused data", r, 32'h0);
    end
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h1a, "status unchanged");
    $display("test refusals done");
    ce <= 1'b0;
    hpdb_host_model_inst.xfer(1'b1, hpdb_pkg::HOST_CTRL_ADR, 8'h00, q8);
    ce <= 1'b1;
    rd(hpdb_pkg::CORE_STATUS_OFS, 32'h1a, "frozen flags");
    $display("test freeze done");
    stop_test();
  end
endmodule : tb_hpdb_host_port
